/* File: hw/pmuda_pkg.sv */
// Constants, command field layout and correction arithmetic for the DAC register bank.
package pmuda_pkg;
	localparam int NCH = 4;
	localparam int NF = 5;
	localparam int NR = 6;
	localparam int DW = 16;
	localparam int CMD_W = 29;
	localparam int RW_BIT = 28;
	localparam int CH_HI = 27;
	localparam int CH_LO = 24;
	localparam int MODE_HI = 23;
	localparam int MODE_LO = 22;
	localparam int FN_HI = 21;
	localparam int FN_LO = 19;
	localparam int RG_HI = 18;
	localparam int RG_LO = 16;
	localparam int DAT_HI = 15;
	localparam int RS_W = 3;
	typedef enum logic [1:0] {
		MODE_CTRL = 2'h0,
		MODE_GAIN = 2'h1,
		MODE_OFFS = 2'h2,
		MODE_INPUT = 2'h3
	} pmuda_mode_t;
	localparam logic [2:0] FN_OFFSET_DAC = 3'h0;
	localparam logic [2:0] FN_FORCE = 3'h1;
	localparam logic [2:0] FN_CLAMP_LO = 3'h2;
	localparam logic [2:0] FN_CLAMP_HI = 3'h3;
	localparam logic [2:0] FN_COMP_HI = 3'h5;
	localparam logic [2:0] RG_OFFSET_DAC = 3'h0;
	localparam logic [2:0] RG_EXT = 3'h4;
	localparam logic [2:0] RG_VOLT = 3'h5;
	localparam logic [2:0] IDX_FORCE = 3'h0;
	localparam logic [2:0] IDX_CLAMP_LO = 3'h1;
	localparam logic [2:0] IDX_CLAMP_HI = 3'h2;
	localparam logic [2:0] IDX_COMP_LO = 3'h3;
	localparam logic [2:0] IDX_COMP_HI = 3'h4;
	localparam logic [15:0] INP_RST = 16'h0000;
	localparam logic [15:0] GAIN_RST = 16'hffff;
	localparam logic [15:0] OFST_RST = 16'h8000;
	localparam logic [15:0] CORR_RST = 16'h0000;
	localparam logic [15:0] OFFS_RST = 16'h0000;
	localparam logic [15:0] CODE_MAX = 16'hffff;
	localparam logic signed [18:0] C_MID = 19'sh08000;

	// Corrected code: input * (gain + 1) / 2^16 + offset term - midscale, saturated to the code range.
	function automatic logic [15:0] pmuda_corr(input logic [15:0] code, input logic [15:0] gain,
		input logic [15:0] ofst);
		logic [32:0] prod;
		logic signed [18:0] sum;
		prod = {17'h00000, code} * {16'h0000, {1'b0, gain} + 17'h00001};
		sum = $signed({3'h0, prod[31:16]}) + $signed({3'h0, ofst}) - C_MID;
		if (sum < 0) begin
			pmuda_corr = 16'h0000;
		end else if (sum > $signed({3'h0, CODE_MAX})) begin
			pmuda_corr = CODE_MAX;
		end else begin
			pmuda_corr = sum[15:0];
		end
	endfunction : pmuda_corr

	// Position of the set bit in a one-hot channel mask.
	function automatic logic [1:0] pmuda_chan_idx(input logic [3:0] mask);
		pmuda_chan_idx = mask[3] ? 2'h3 : mask[2] ? 2'h2 : mask[1] ? 2'h1 : 2'h0;
	endfunction : pmuda_chan_idx
endpackage : pmuda_pkg

/* File: hw/pmuda_bank.sv */
// DAC register bank: command decode, coefficient storage, corrected codes and readback.
// What this block does
// - Bits 21:19 pick force, clamp low/high or comparator low/high DAC.
// - Bits 18:16 pick one of four current ranges, external or voltage.
// - Bits 15:0 carry the 16-bit DAC value, bit 15 most significant.
// - Force and comparators have six register sets; clamps only two.
// - Corrected code is computed only on input register writes.
// - Gain and offset coefficients are volatile and reset to defaults.
// - One offset DAC is shared and answers any channel select bit.
// - Offset DAC has only an input register at function and range zero.
// - Readback uses the same function and range decoding as writes.
// - When forcing voltage, clamps use the current set at range 100.
// - When forcing current, clamps use the voltage set at range 101.
// - Channel bits 27:24 each enable one channel; writes allow any mix, reads need exactly one bit set.
`timescale 1ns/10ps
module pmuda_bank (
	input wire logic clk,
	input wire logic rst,
	input wire logic ce,
	input wire logic [28:0] cmd_word,
	input wire logic cmd_valid,
	input wire logic [3:0] force_voltage,
	input wire logic [11:0] range_select,
	output logic [63:0] force_lvl_code,
	output logic [63:0] comp_lo_code,
	output logic [63:0] comp_hi_code,
	output logic [63:0] clamp_lo_code,
	output logic [63:0] clamp_hi_code,
	output logic [15:0] offset_dac_code,
	output logic [15:0] rd_data,
	output logic rd_valid
);
	logic [pmuda_pkg::NCH-1:0][pmuda_pkg::NF-1:0][pmuda_pkg::NR-1:0][15:0] inp_reg, inp_next;
	logic [pmuda_pkg::NCH-1:0][pmuda_pkg::NF-1:0][pmuda_pkg::NR-1:0][15:0] gain_reg, gain_next;
	logic [pmuda_pkg::NCH-1:0][pmuda_pkg::NF-1:0][pmuda_pkg::NR-1:0][15:0] ofst_reg, ofst_next;
	logic [pmuda_pkg::NCH-1:0][pmuda_pkg::NF-1:0][pmuda_pkg::NR-1:0][15:0] corr_reg, corr_next;
	logic [15:0] offs_reg, offs_next;
	logic [15:0] rd_data_reg, rd_data_next;
	logic rd_valid_reg, rd_valid_next;
	logic [63:0] force_reg, force_next, comp_lo_reg, comp_lo_next, comp_hi_reg, comp_hi_next;
	logic [63:0] clamp_lo_reg, clamp_lo_next, clamp_hi_reg, clamp_hi_next;
	logic cmd_rw;
	logic [3:0] cmd_chan;
	pmuda_pkg::pmuda_mode_t cmd_mode;
	logic [2:0] cmd_fn, cmd_rg, fi;
	logic [15:0] cmd_data;
	logic dac_addr_ok, offs_addr, wr_dac, wr_offs, rd_req;
	logic [1:0] rd_ch;
	logic [15:0] rd_pick;
	logic [15:0] hlp_corr0;

	// Field split of the command word.
	assign cmd_rw = cmd_word[pmuda_pkg::RW_BIT];
	assign cmd_chan = cmd_word[pmuda_pkg::CH_HI:pmuda_pkg::CH_LO];
	assign cmd_mode = pmuda_pkg::pmuda_mode_t'(cmd_word[pmuda_pkg::MODE_HI:pmuda_pkg::MODE_LO]);
	assign cmd_fn = cmd_word[pmuda_pkg::FN_HI:pmuda_pkg::FN_LO];
	assign cmd_rg = cmd_word[pmuda_pkg::RG_HI:pmuda_pkg::RG_LO];
	assign cmd_data = cmd_word[pmuda_pkg::DAT_HI:0];
	assign fi = cmd_fn - pmuda_pkg::FN_FORCE;

	// Address legality; clamps accept only the external and voltage sets.
	assign dac_addr_ok = (cmd_fn >= pmuda_pkg::FN_FORCE) && (cmd_fn <= pmuda_pkg::FN_COMP_HI)
		&& (cmd_rg <= pmuda_pkg::RG_VOLT)
		&& !(((cmd_fn == pmuda_pkg::FN_CLAMP_LO) || (cmd_fn == pmuda_pkg::FN_CLAMP_HI))
		&& (cmd_rg < pmuda_pkg::RG_EXT));
	assign offs_addr = (cmd_fn == pmuda_pkg::FN_OFFSET_DAC) && (cmd_rg == pmuda_pkg::RG_OFFSET_DAC);

	// Request qualification; anything reserved falls through untouched.
	assign wr_dac = cmd_valid && !cmd_rw && (cmd_mode != pmuda_pkg::MODE_CTRL) && dac_addr_ok;
	assign wr_offs = cmd_valid && !cmd_rw && (cmd_mode == pmuda_pkg::MODE_INPUT) && offs_addr
		&& (cmd_chan != 4'h0);
	assign rd_req = cmd_valid && cmd_rw && (cmd_mode != pmuda_pkg::MODE_CTRL)
		&& (cmd_chan != 4'h0) && ((cmd_chan & (cmd_chan - 4'h1)) == 4'h0)
		&& (dac_addr_ok || (offs_addr && (cmd_mode == pmuda_pkg::MODE_INPUT)));
	assign rd_ch = pmuda_pkg::pmuda_chan_idx(cmd_chan);
	assign hlp_corr0 = pmuda_pkg::pmuda_corr(cmd_data, gain_reg[0][fi][cmd_rg], ofst_reg[0][fi][cmd_rg]);

	// Readback selection mirrors the write decode so one address means one register.
	always_comb begin
		rd_pick = rd_data_reg;
		if (offs_addr) begin
			rd_pick = offs_reg;
		end else begin
			unique case (cmd_mode)
				pmuda_pkg::MODE_GAIN: rd_pick = gain_reg[rd_ch][fi][cmd_rg];
				pmuda_pkg::MODE_OFFS: rd_pick = ofst_reg[rd_ch][fi][cmd_rg];
				pmuda_pkg::MODE_INPUT: rd_pick = inp_reg[rd_ch][fi][cmd_rg];
				pmuda_pkg::MODE_CTRL: rd_pick = rd_data_reg;
			endcase
		end
	end

	// Next state of the storage arrays and the readback port.
	always_comb begin
		inp_next = inp_reg;
		gain_next = gain_reg;
		ofst_next = ofst_reg;
		corr_next = corr_reg;
		offs_next = offs_reg;
		rd_valid_next = 1'b0;
		rd_data_next = rd_data_reg;
		if (wr_dac) begin
			for (int ch = 0; ch < pmuda_pkg::NCH; ch++) begin
				if (cmd_chan[ch]) begin
					unique case (cmd_mode)
						pmuda_pkg::MODE_GAIN: gain_next[ch][fi][cmd_rg] = cmd_data;
						pmuda_pkg::MODE_OFFS: ofst_next[ch][fi][cmd_rg] = cmd_data;
						pmuda_pkg::MODE_INPUT: begin
							inp_next[ch][fi][cmd_rg] = cmd_data;
							// Only an input load refreshes the corrected code.
							corr_next[ch][fi][cmd_rg] = pmuda_pkg::pmuda_corr(cmd_data,
								gain_reg[ch][fi][cmd_rg], ofst_reg[ch][fi][cmd_rg]);
						end
						pmuda_pkg::MODE_CTRL: inp_next[ch] = inp_reg[ch];
					endcase
				end
			end
		end
		if (wr_offs) begin
			offs_next = cmd_data;
		end
		if (rd_req) begin
			rd_valid_next = 1'b1;
			rd_data_next = rd_pick;
		end
	end

	// Live DAC codes per channel; an illegal range select falls back to the voltage set.
	always_comb begin
		logic [2:0] r;
		logic [2:0] cs;
		r = 3'h0;
		cs = 3'h0;
		force_next = force_reg;
		comp_lo_next = comp_lo_reg;
		comp_hi_next = comp_hi_reg;
		clamp_lo_next = clamp_lo_reg;
		clamp_hi_next = clamp_hi_reg;
		for (int ch = 0; ch < pmuda_pkg::NCH; ch++) begin
			r = range_select[ch*pmuda_pkg::RS_W +: pmuda_pkg::RS_W];
			if (r > pmuda_pkg::RG_VOLT) begin
				r = pmuda_pkg::RG_VOLT;
			end
			// Forcing voltage engages current clamps, forcing current engages voltage clamps.
			cs = force_voltage[ch] ? pmuda_pkg::RG_EXT : pmuda_pkg::RG_VOLT;
			force_next[ch*pmuda_pkg::DW +: pmuda_pkg::DW] = corr_reg[ch][pmuda_pkg::IDX_FORCE][r];
			comp_lo_next[ch*pmuda_pkg::DW +: pmuda_pkg::DW] = corr_reg[ch][pmuda_pkg::IDX_COMP_LO][r];
			comp_hi_next[ch*pmuda_pkg::DW +: pmuda_pkg::DW] = corr_reg[ch][pmuda_pkg::IDX_COMP_HI][r];
			clamp_lo_next[ch*pmuda_pkg::DW +: pmuda_pkg::DW] = corr_reg[ch][pmuda_pkg::IDX_CLAMP_LO][cs];
			clamp_hi_next[ch*pmuda_pkg::DW +: pmuda_pkg::DW] = corr_reg[ch][pmuda_pkg::IDX_CLAMP_HI][cs];
		end
	end

	// Registers; the coefficients are plain flip-flops and return to defaults on reset.
	always_ff @(posedge clk) begin
		if (rst) begin
			inp_reg <= {(pmuda_pkg::NCH*pmuda_pkg::NF*pmuda_pkg::NR){pmuda_pkg::INP_RST}};
			gain_reg <= {(pmuda_pkg::NCH*pmuda_pkg::NF*pmuda_pkg::NR){pmuda_pkg::GAIN_RST}};
			ofst_reg <= {(pmuda_pkg::NCH*pmuda_pkg::NF*pmuda_pkg::NR){pmuda_pkg::OFST_RST}};
			corr_reg <= {(pmuda_pkg::NCH*pmuda_pkg::NF*pmuda_pkg::NR){pmuda_pkg::CORR_RST}};
			offs_reg <= pmuda_pkg::OFFS_RST;
			rd_data_reg <= 16'h0000;
			rd_valid_reg <= 1'b0;
			force_reg <= 64'h0;
			comp_lo_reg <= 64'h0;
			comp_hi_reg <= 64'h0;
			clamp_lo_reg <= 64'h0;
			clamp_hi_reg <= 64'h0;
		end else if (ce) begin
			inp_reg <= inp_next;
			gain_reg <= gain_next;
			ofst_reg <= ofst_next;
			corr_reg <= corr_next;
			offs_reg <= offs_next;
			rd_data_reg <= rd_data_next;
			rd_valid_reg <= rd_valid_next;
			force_reg <= force_next;
			comp_lo_reg <= comp_lo_next;
			comp_hi_reg <= comp_hi_next;
			clamp_lo_reg <= clamp_lo_next;
			clamp_hi_reg <= clamp_hi_next;
		end
	end

	assign force_lvl_code = force_reg;
	assign comp_lo_code = comp_lo_reg;
	assign comp_hi_code = comp_hi_reg;
	assign clamp_lo_code = clamp_lo_reg;
	assign clamp_hi_code = clamp_hi_reg;
	assign offset_dac_code = offs_reg;
	assign rd_data = rd_data_reg;
	assign rd_valid = rd_valid_reg;

	// Coefficient writes must leave every corrected code alone.
	AST_NO_RECALC: assert property (@(posedge clk) disable iff (rst)
		ce && wr_dac && (cmd_mode != pmuda_pkg::MODE_INPUT) |=> $stable(corr_reg))
		else $error("corrected code moved on a coefficient write");

	// An input write to channel zero yields the correction of the old coefficients.
	AST_RECALC: assert property (@(posedge clk) disable iff (rst)
		ce && wr_dac && (cmd_mode == pmuda_pkg::MODE_INPUT) && cmd_chan[0]
		|=> corr_reg[0][$past(fi)][$past(cmd_rg)] == $past(hlp_corr0))
		else $error("corrected code wrong after input write");

	// Reserved combinations change no stored register.
	AST_RESERVED: assert property (@(posedge clk) disable iff (rst)
		ce && cmd_valid && !cmd_rw && !wr_dac && !wr_offs
		|=> $stable(inp_reg) && $stable(gain_reg) && $stable(ofst_reg) && $stable(offs_reg))
		else $error("reserved write changed a register");

	// Any single channel bit reaches the shared offset DAC.
	AST_OFFSET_DAC: assert property (@(posedge clk) disable iff (rst)
		ce && wr_offs |=> offset_dac_code == $past(cmd_data) && $stable(inp_reg))
		else $error("offset DAC not loaded");

	// A cleared channel 1 bit protects channel 1.
	AST_CHAN_MASK: assert property (@(posedge clk) disable iff (rst)
		ce && wr_dac && !cmd_chan[1] |=> $stable(inp_reg[1]) && $stable(gain_reg[1]) && $stable(ofst_reg[1]))
		else $error("unselected channel written");

	// Voltage forcing feeds the clamp from the current set.
	AST_CLAMP_V: assert property (@(posedge clk) disable iff (rst)
		ce && force_voltage[0]
		|=> clamp_lo_code[15:0] == $past(corr_reg[0][pmuda_pkg::IDX_CLAMP_LO][pmuda_pkg::RG_EXT]))
		else $error("clamp low not from current set");

	// Current forcing feeds the clamp from the voltage set.
	AST_CLAMP_I: assert property (@(posedge clk) disable iff (rst)
		ce && !force_voltage[2]
		|=> clamp_hi_code[47:32] == $past(corr_reg[2][pmuda_pkg::IDX_CLAMP_HI][pmuda_pkg::RG_VOLT]))
		else $error("clamp high not from voltage set");

	// A legal read answers one cycle later; the pulse only repeats for a back-to-back request.
	AST_READBACK: assert property (@(posedge clk) disable iff (rst)
		ce && rd_req ##1 ce |-> (rd_valid && (rd_data == $past(rd_pick))) ##1 (rd_valid == $past(rd_req)))
		else $error("readback wrong");

	// Clamp sets below the external range never take a write, so they keep their reset values.
	AST_CLAMP_SETS: assert property (@(posedge clk) disable iff (rst)
		ce |-> (gain_reg[3][pmuda_pkg::IDX_CLAMP_LO][0] == pmuda_pkg::GAIN_RST)
		&& (ofst_reg[3][pmuda_pkg::IDX_CLAMP_LO][0] == pmuda_pkg::OFST_RST))
		else $error("reserved clamp set written");
endmodule : pmuda_bank

/* File: tb/pmuda_host.sv */
// Host controller model that sends command words to the DAC register bank.
`timescale 1ns/10ps
module pmuda_host (
	input wire logic clk,
	input wire logic [15:0] rd_data,
	input wire logic rd_valid,
	output logic [28:0] cmd_word,
	output logic cmd_valid
);
	initial begin
		cmd_word = 29'h0;
		cmd_valid = 1'b0;
	end

	// One word per call; after release the bus shows the inverse so a stale word is never mistaken for a new one.
	task automatic send(input logic rw, input logic [3:0] mask, input logic [1:0] mode, input logic [2:0] fn,
		input logic [2:0] rg, input logic [15:0] data);
		@(negedge clk);
		cmd_word = {rw, mask, mode, fn, rg, data};
		cmd_valid = 1'b1;
		@(negedge clk);
		cmd_valid = 1'b0;
		cmd_word = ~cmd_word;
	endtask : send

	// Readback request followed by a bounded wait for the one-cycle answer pulse.
	task automatic read(input logic [3:0] mask, input logic [1:0] mode, input logic [2:0] fn, input logic [2:0] rg,
		output logic [15:0] data, output logic ok);
		int n;
		ok = 1'b0;
		data = 16'h0000;
		send(1'b1, mask, mode, fn, rg, 16'h0000);
		for (n = 0; n < 4 && !ok; n++) begin
			if (rd_valid === 1'b1) begin
				ok = 1'b1;
				data = rd_data;
			end else begin
				@(negedge clk);
			end
		end
	endtask : read
endmodule : pmuda_host

/* File: tb/pmuda_bank_tb_top.sv */
// Self-checking testbench for the DAC register bank.
`timescale 1ns/10ps
module pmuda_bank_tb_top;
	logic clk = 1'b0;
	logic rst = 1'b1;
	logic ce = 1'b1;
	logic [28:0] cmd_word;
	logic cmd_valid;
	logic [3:0] force_voltage = 4'h0;
	logic [11:0] range_select = 12'h000;
	logic [63:0] force_lvl_code, comp_lo_code, comp_hi_code, clamp_lo_code, clamp_hi_code;
	logic [15:0] offset_dac_code, rd_data, d;
	logic rd_valid;
	int error_cnt = 0;
	int total_checks = 0;
	logic [28:0] rsv [6];

	always #5 clk = ~clk;

	pmuda_bank pmuda_bank_i (.clk(clk), .rst(rst), .ce(ce), .cmd_word(cmd_word), .cmd_valid(cmd_valid),
		.force_voltage(force_voltage), .range_select(range_select), .force_lvl_code(force_lvl_code),
		.comp_lo_code(comp_lo_code), .comp_hi_code(comp_hi_code), .clamp_lo_code(clamp_lo_code),
		.clamp_hi_code(clamp_hi_code),
		.offset_dac_code(offset_dac_code), .rd_data(rd_data), .rd_valid(rd_valid));

	pmuda_host pmuda_host_i (.clk(clk), .rd_data(rd_data), .rd_valid(rd_valid), .cmd_word(cmd_word),
		.cmd_valid(cmd_valid));

	task automatic print_verdict();
		if (error_cnt == 0 && total_checks > 0) begin
			$display("verification passed");
		end else begin
			$display("verification failed");
		end
		$finish;
	endtask : print_verdict

	task automatic cmp16(input logic [15:0] got, input logic [15:0] exp);
		total_checks++;
		if (got !== exp) begin
			error_cnt++;
			$display("unexpected value at %0t: got %h, expected %h", $time, got, exp);
		end
	endtask : cmp16

	// Read with a bounded wait; a missing answer ends the run.
	task automatic rd(input logic [3:0] mask, input logic [1:0] mode, input logic [2:0] fn, input logic [2:0] rg);
		logic ok;
		pmuda_host_i.read(mask, mode, fn, rg, d, ok);
		if (!ok) begin
			error_cnt++;
			$display("unexpected missing readback at %0t", $time);
			print_verdict();
		end
	endtask : rd

	// Live codes follow a write two edges later, so two falling edges are enough.
	task automatic settle();
		repeat (2) @(negedge clk);
	endtask : settle

	// Saturated correction worked out independently of the design.
	function automatic logic [15:0] corr(input longint code, input longint gain, input longint ofst);
		longint s;
		s = ((code * (gain + 1)) >>> 16) + ofst - 32768;
		corr = (s < 0) ? 16'h0000 : (s > 65535) ? 16'hffff : s[15:0];
	endfunction : corr

	initial begin
		repeat (10) @(negedge clk);
		rst = 1'b0;
		cmp16(force_lvl_code[15:0], 16'h0000);
		// Broadcast input write to every channel, then read one channel back.
		pmuda_host_i.send(1'b0, 4'hf, 2'h3, 3'h1, 3'h0, 16'h1234);
		settle();
		for (int ch = 0; ch < 4; ch++) begin
			cmp16(force_lvl_code[16*ch+:16], corr(16'h1234, 16'hffff, 16'h8000));
		end
		rd(4'h4, 2'h3, 3'h1, 3'h0);
		cmp16(d, 16'h1234);
		// Coefficients alone must not move the corrected code.
		range_select = 12'h205;
		pmuda_host_i.send(1'b0, 4'h1, 2'h1, 3'h4, 3'h5, 16'h7fff);
		pmuda_host_i.send(1'b0, 4'h1, 2'h2, 3'h4, 3'h5, 16'h9000);
		settle();
		cmp16(comp_lo_code[15:0], 16'h0000);
		pmuda_host_i.send(1'b0, 4'h1, 2'h3, 3'h4, 3'h5, 16'h4000);
		pmuda_host_i.send(1'b0, 4'h1, 2'h3, 3'h4, 3'h3, 16'h1111);
		pmuda_host_i.send(1'b0, 4'h8, 2'h3, 3'h5, 3'h1, 16'habcd);
		settle();
		cmp16(comp_lo_code[15:0], corr(16'h4000, 16'h7fff, 16'h9000));
		cmp16(comp_lo_code[31:16], 16'h0000);
		cmp16(comp_hi_code[63:48], 16'habcd);
		rd(4'h1, 2'h1, 3'h4, 3'h5);
		cmp16(d, 16'h7fff);
		rd(4'h1, 2'h2, 3'h4, 3'h5);
		cmp16(d, 16'h9000);
		range_select = 12'h203;
		settle();
		cmp16(comp_lo_code[15:0], 16'h1111);
		// Two clamp sets, chosen by the force mode of the channel.
		pmuda_host_i.send(1'b0, 4'h2, 2'h3, 3'h2, 3'h4, 16'haaaa);
		pmuda_host_i.send(1'b0, 4'h2, 2'h3, 3'h3, 3'h4, 16'h2468);
		pmuda_host_i.send(1'b0, 4'h2, 2'h3, 3'h2, 3'h5, 16'h1357);
		pmuda_host_i.send(1'b0, 4'h2, 2'h3, 3'h3, 3'h5, 16'h5555);
		force_voltage = 4'h2;
		settle();
		cmp16(clamp_lo_code[31:16], 16'haaaa);
		cmp16(clamp_hi_code[31:16], 16'h2468);
		force_voltage = 4'h0;
		settle();
		cmp16(clamp_lo_code[31:16], 16'h1357);
		cmp16(clamp_hi_code[31:16], 16'h5555);
		// Shared offset DAC through a single upper channel bit; gain mode there is reserved.
		pmuda_host_i.send(1'b0, 4'h4, 2'h3, 3'h0, 3'h0, 16'h9abc);
		pmuda_host_i.send(1'b0, 4'h1, 2'h1, 3'h0, 3'h0, 16'h0001);
		settle();
		cmp16(offset_dac_code, 16'h9abc);
		rd(4'h8, 2'h3, 3'h0, 3'h0);
		cmp16(d, 16'h9abc);
		// Reserved mode, function and range codes, and a clamp below the external range, change nothing.
		rsv = '{29'h0f080000, 29'h0ff00000, 29'h0fce0000, 29'h0ff80000, 29'h0fcf0000, 29'h08500000};
		foreach (rsv[i]) begin
			pmuda_host_i.send(1'b0, rsv[i][27:24], rsv[i][23:22], rsv[i][21:19], rsv[i][18:16], 16'hdead);
		end
		ce = 1'b0;
		pmuda_host_i.send(1'b0, 4'hf, 2'h3, 3'h1, 3'h0, 16'h0bad);
		ce = 1'b1;
		settle();
		cmp16(force_lvl_code[47:32], 16'h1234);
		cmp16(offset_dac_code, 16'h9abc);
		rd(4'h2, 2'h3, 3'h1, 3'h0);
		cmp16(d, 16'h1234);
		// A mid-run reset must drop the volatile coefficients back to their defaults.
		rst = 1'b1;
		repeat (2) @(negedge clk);
		rst = 1'b0;
		cmp16(force_lvl_code[47:32], pmuda_pkg::CORR_RST);
		cmp16(offset_dac_code, pmuda_pkg::OFFS_RST);
		rd(4'h1, 2'h1, 3'h4, 3'h5);
		cmp16(d, pmuda_pkg::GAIN_RST);
		rd(4'h1, 2'h2, 3'h4, 3'h5);
		cmp16(d, pmuda_pkg::OFST_RST);
		print_verdict();
	end
endmodule : pmuda_bank_tb_top
